// ==== rtl/tpp_pkg.sv ====
// Constants shared by the two-pin port and its pullup control.
// Assumes one bus clock, synchronous reset and an 8-bit register port.
// ****************************************************************
// ****************************************************************
package tpp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_NARROW_LATCH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_NARROW_DIR = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_WIDE_PULLUP = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_WIDE_DIR = 8'h0B;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_CTRL = 8'h0C;
  localparam int unsigned NARROW_PINS = 2;
  localparam int unsigned WIDE_PINS = 8;
  localparam int unsigned BIT_RECEIVE = 1;
  localparam int unsigned BIT_TRANSMIT = 0;
  localparam int unsigned BIT_SERIAL_EN = 0;
  localparam logic [1:0] RST_NARROW_DIR = 2'h0;
  localparam logic [1:0] RST_NARROW_LATCH = 2'h0;
  localparam logic [7:0] RST_WIDE_PULLUP = 8'h00;
  localparam logic [7:0] RST_WIDE_DIR = 8'h00;
  localparam logic RST_SERIAL_EN = 1'b0;
endpackage : tpp_pkg

// ==== rtl/tpp_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the levels are static for at least a few clock periods.
`timescale 1ns/10ps
module tpp_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  // The first stage feeds only the second, so metastability is contained.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule : tpp_sync

// ==== rtl/tpp_port.sv ====
// Two-pin port shared with a serial unit, plus the wide port pullups.
// Assumes a single-cycle register port and raw pin levels from pads.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module tpp_port (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [tpp_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tpp_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [tpp_pkg::DATA_W-1:0] rdata_out,
  input wire logic [tpp_pkg::NARROW_PINS-1:0] narrow_pin_in,
  output logic [tpp_pkg::NARROW_PINS-1:0] narrow_pin_out,
  output logic [tpp_pkg::NARROW_PINS-1:0] narrow_pin_oe_out,
  input wire logic serial_tx_in,
  output logic serial_rx_out,
  output logic serial_unit_enable_out,
  output logic [tpp_pkg::WIDE_PINS-1:0] wide_pullup_on_out
);
  import tpp_pkg::*;

  logic [NARROW_PINS-1:0] narrow_port_latch_q;
  logic [NARROW_PINS-1:0] narrow_port_direction_q;
  logic [WIDE_PINS-1:0] wide_port_pullup_bits_q;
  logic [WIDE_PINS-1:0] wide_port_direction_q;
  logic serial_unit_enable_q;
  logic [NARROW_PINS-1:0] pin_sync;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [NARROW_PINS-1:0] serial_owns;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************************************
  // Pin input synchronisation
  // ****************************************************************
  tpp_sync #(
    .WIDTH(NARROW_PINS)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(narrow_pin_in),
    .sync_out(pin_sync)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Latch writes land whatever the direction bit says.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      narrow_port_latch_q <= RST_NARROW_LATCH;
    end else if (wr_in && hit(addr_in, OFS_NARROW_LATCH)) begin
      narrow_port_latch_q <= wdata_in[NARROW_PINS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      narrow_port_direction_q <= RST_NARROW_DIR;
    end else if (wr_in && hit(addr_in, OFS_NARROW_DIR)) begin
      narrow_port_direction_q <= wdata_in[NARROW_PINS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wide_port_pullup_bits_q <= RST_WIDE_PULLUP;
    end else if (wr_in && hit(addr_in, OFS_WIDE_PULLUP)) begin
      wide_port_pullup_bits_q <= wdata_in[WIDE_PINS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wide_port_direction_q <= RST_WIDE_DIR;
    end else if (wr_in && hit(addr_in, OFS_WIDE_DIR)) begin
      wide_port_direction_q <= wdata_in[WIDE_PINS-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_unit_enable_q <= RST_SERIAL_EN;
    end else if (wr_in && hit(addr_in, OFS_SERIAL_CTRL)) begin
      serial_unit_enable_q <= wdata_in[BIT_SERIAL_EN];
    end
  end

  // ****************************************************************
  // Pin control
  // ****************************************************************
  // Both shared pins go to the serial unit together with its enable.
  assign serial_owns = {NARROW_PINS{serial_unit_enable_q}};

  always_comb begin
    narrow_pin_out = narrow_port_latch_q;
    narrow_pin_oe_out = narrow_port_direction_q;
    // Serial use overrides the direction bits on its pins.
    if (serial_owns[BIT_TRANSMIT]) begin
      narrow_pin_out[BIT_TRANSMIT] = serial_tx_in;
      narrow_pin_oe_out[BIT_TRANSMIT] = 1'b1;
    end
    if (serial_owns[BIT_RECEIVE]) begin
      narrow_pin_oe_out[BIT_RECEIVE] = 1'b0;
    end
  end

  // Idle line is high, so the receiver sees mark while disabled.
  assign serial_rx_out = serial_unit_enable_q ?
                         pin_sync[BIT_RECEIVE] : 1'b1;
  assign serial_unit_enable_out = serial_unit_enable_q;

  genvar g;
  generate
    for (g = 0; g < WIDE_PINS; g++) begin : g_pullup
      assign wide_pullup_on_out[g] = wide_port_pullup_bits_q[g] &
                                     ~wide_port_direction_q[g];
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_d = '0;
    case (1'b1)
      hit(addr_in, OFS_NARROW_LATCH): begin
        // Direction still picks latch or pin even under serial use.
        rdata_d[NARROW_PINS-1:0] =
          (narrow_port_direction_q & narrow_port_latch_q) |
          (~narrow_port_direction_q & pin_sync);
      end
      hit(addr_in, OFS_NARROW_DIR): begin
        rdata_d[NARROW_PINS-1:0] = narrow_port_direction_q;
      end
      hit(addr_in, OFS_WIDE_PULLUP): begin
        rdata_d[WIDE_PINS-1:0] = wide_port_pullup_bits_q;
      end
      hit(addr_in, OFS_WIDE_DIR): begin
        rdata_d[WIDE_PINS-1:0] = wide_port_direction_q;
      end
      hit(addr_in, OFS_SERIAL_CTRL): begin
        rdata_d[BIT_SERIAL_EN] = serial_unit_enable_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (rd_in) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end
  assign rdata_out = rdata_q;
endmodule : tpp_port

// ==== verif/tpp_port_props.sv ====
// Checker for the two-pin port, bound to its top-level ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tpp_port_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic [1:0] narrow_pin_in,
  input wire logic [1:0] narrow_pin_out,
  input wire logic [1:0] narrow_pin_oe_out,
  input wire logic serial_tx_in,
  input wire logic serial_rx_out,
  input wire logic serial_unit_enable_out,
  input wire logic [7:0] wide_pullup_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // Checks
  // ****
  a_pullup_dir_off: assert property (
    wr_in && addr_in == 8'h0B |=> !(wide_pullup_on_out & $past(wdata_in)))
    else $error("pullup on for output");
  a_dir_sets_oe: assert property (
    wr_in && addr_in == 8'h09 && !serial_unit_enable_out
    |=> narrow_pin_oe_out == $past(wdata_in[1:0])) else $error("oe");
  a_serial_owns_oe: assert property (
    serial_unit_enable_out |-> narrow_pin_oe_out == 2'h1) else $error("soe");
  a_serial_tx_drive: assert property (
    serial_unit_enable_out |-> narrow_pin_out[0] == serial_tx_in)
    else $error("tx");
  a_rx_idle_off: assert property (
    !serial_unit_enable_out |-> serial_rx_out) else $error("rx idle");
  a_reset_dir_in: assert property (
    $fell(rst_in) |-> narrow_pin_oe_out == 2'h0) else $error("reset oe");
  a_serial_bit_wr: assert property (
    wr_in && addr_in == 8'h0C |=> serial_unit_enable_out == $past(wdata_in[0]))
    else $error("enable");
  a_rx_route_sync: assert property (
    serial_unit_enable_out [*3] |-> serial_rx_out == $past(narrow_pin_in[1], 2))
    else $error("rx route");
  cover property (wr_in && addr_in == 8'h0C && wdata_in[0]);
  cover property (wr_in && addr_in == 8'h0B && wdata_in != 8'h00);
  cover property (serial_unit_enable_out [*3]);
endmodule : tpp_port_props
bind tpp_port tpp_port_props i_tpp_port_props (.*);

// ==== verif/tpp_pads.sv ====
// Pads and serial unit on the far side of the two-pin port.
// Assumes the bench sets the level an outside device puts on each pin.
`timescale 1ns/10ps
module tpp_pads (
  input wire logic clk_in,
  input wire logic [1:0] drive_in,
  input wire logic [1:0] oe_in,
  input wire logic [1:0] ext_in,
  input wire logic enable_in,
  output logic [1:0] pin_out,
  output logic tx_out
);
  logic tx_q = 1'b1;
  // A driven pin shows the port's value, an undriven one the outside.
  assign pin_out = (oe_in & drive_in) | (~oe_in & ext_in);
  // Toggling while enabled makes a wrong routing show within a cycle.
  always @(posedge clk_in) tx_q <= enable_in ? ~tx_q : 1'b1;
  assign tx_out = tx_q;
endmodule : tpp_pads

// ==== verif/tpp_port_test.sv ====
// Self-checking bench for the two-pin port and wide pullup control.
// Assumes the pad model drives pins and the serial transmit level.
`timescale 1ns/10ps
module tpp_port_test;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, wide_pullup_on_out;
  logic [1:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe_out, ext = 2'h2;
  logic serial_tx_in, serial_rx_out, serial_unit_enable_out;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  tpp_port i_tpp_port (.*);
  tpp_pads i_tpp_pads (.clk_in, .drive_in(narrow_pin_out),
    .oe_in(narrow_pin_oe_out), .ext_in(ext), .enable_in(serial_unit_enable_out),
    .pin_out(narrow_pin_in), .tx_out(serial_tx_in));
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cyc == 3000) begin
    error_cnt++;
    give_verdict();
  end
  // ****
  // Tasks
  // ****
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 cmp(rdata_out, e);
  endtask : rd
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(8'h08, 8'h02);
    for (int a = 9; a < 14; a++) rd(8'(a), 8'h00);
    cmp({6'h00, narrow_pin_oe_out}, 8'h00);
    wr(8'h08, 8'h01);
    cmp({6'h00, narrow_pin_oe_out}, 8'h00);
    wr(8'h09, 8'h03);
    cmp({4'h0, narrow_pin_oe_out, narrow_pin_out}, 8'h0D);
    rd(8'h08, 8'h01);
    ext <= 2'h0;
    wr(8'h09, 8'h01);
    wr(8'h08, 8'h03);
    rd(8'h08, 8'h01);
    wr(8'h0A, 8'hFF);
    cmp(wide_pullup_on_out, 8'hFF);
    wr(8'h0B, 8'h0F);
    cmp(wide_pullup_on_out, 8'hF0);
    rd(8'h0B, 8'h0F);
    wr(8'h09, 8'h03);
    wr(8'h0C, 8'h01);
    cmp({6'h00, narrow_pin_oe_out}, 8'h01);
    rd(8'h08, 8'h03);
    rd(8'h0C, 8'h01);
    cmp({7'h00, serial_unit_enable_out}, 8'h01);
    repeat (3) @(posedge clk_in);
    #1 cmp({7'h00, serial_rx_out}, 8'h00);
    cmp({7'h00, narrow_pin_out[0]}, {7'h00, serial_tx_in});
    wr(8'h0C, 8'h00);
    cmp({5'h00, serial_rx_out, narrow_pin_oe_out}, 8'h07);
    give_verdict();
  end
endmodule : tpp_port_test
